// >>> inc/core_params.svh
/*
  Named constants for the instruction sequencing core: field positions of the
  instruction word, class and function codes, reset values and phase counts.
  Assumes it is included by bare name from the package and the core.
*/
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH
// ----------------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------------
`define PC_W        10
`define DA_W        7
`define IW          14
`define CLKS_PER_CYCLE 4
`define PH_FIRST    2'h0
`define PH_FETCH    2'h0
`define PH_LAST     2'h3
// ----------------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------------
`define CLS_HI 13
`define CLS_LO 10
`define FN_HI  9
`define FN_LO  7
`define IFN_HI 9
`define IFN_LO 8
`define IMM_HI 7
`define IMM_LO 0
`define TBH_HI 13
`define TBH_LO 8
// ----------------------------------------------------------------------
// Classes and functions
// ----------------------------------------------------------------------
`define CLS_ALU_A 4'h0
`define CLS_ALU_M 4'h1
`define CLS_UNI_A 4'h2
`define CLS_UNI_M 4'h3
`define CLS_IMM   4'h4
`define CLS_SKIP  4'h5
`define CLS_BSET  4'h6
`define CLS_BCLR  4'h7
`define CLS_BSKZ  4'h8
`define CLS_BSKNZ 4'h9
`define CLS_JMP   4'ha
`define CLS_CALL  4'hb
`define CLS_SYS   4'hc
`define AF_ADD 3'h0
`define AF_ADC 3'h1
`define AF_SUB 3'h2
`define AF_SBC 3'h3
`define AF_AND 3'h4
`define AF_OR  3'h5
`define AF_XOR 3'h6
`define AF_CPL 3'h7
`define IF_ADD 2'h0
`define IF_SUB 2'h1
`define IF_AND 2'h2
`define IF_MOV 2'h3
`define UF_INC 3'h0
`define UF_DEC 3'h1
`define UF_RR  3'h2
`define UF_RL  3'h3
`define UF_RRC 3'h4
`define UF_RLC 3'h5
`define UF_MOV 3'h6
`define UF_X   3'h7
`define SF_SZ  3'h0
`define SF_SNZ 3'h1
`define SF_SIZ 3'h2
`define SF_SDZ 3'h3
`define YF_RET  3'h1
`define YF_ISR_EXIT 3'h2
`define YF_HALT 3'h3
`define YF_WDT  3'h4
// ----------------------------------------------------------------------
// Addresses and reset values
// ----------------------------------------------------------------------
`define PCL_ADDR 7'h02
`define PC_RST   10'h000
`define ACC_RST  8'h00
`define BYTE_ONE 8'h01
`endif

// >>> inc/core_pkg.sv
/*
  Types shared by the instruction sequencing core.
  Assumes core_params.svh is on the include path.
*/
`include "core_params.svh"
package core_pkg;
  typedef enum logic [1:0] {ST_EXEC, ST_EXTRA, ST_HALT} seq_state_t;
  typedef struct packed {
    logic z;
    logic c;
    logic ac;
    logic ov;
  } flags_t;
  typedef struct packed {
    logic [`DA_W-1:0] addr;
    logic [7:0]       wdata;
    logic             we;
  } dm_req_t;
endpackage

// >>> rtl/mcu_core.sv
/*
  Instruction sequencing core of a small 8-bit accumulator machine: phase
  counter, fetch, decode, ALU, program counter, one-level return stack.
  Assumes program and data memories answer combinationally to the address
  outputs, on the same clock: program memory within one clock, data memory within three.
*/
// Summary of operation
// - Each instruction cycle is four clocks; instructions run in whole cycles.
// - Plain instructions take one cycle; branch, call and table read take two.
// - Jump, call, return and interrupt return take one extra cycle.
// - Writing the program counter low byte jumps there with an extra cycle.
// - Skip costs one cycle, plus one more when the skip is taken.
// - Moves: memory to accumulator, accumulator to memory, immediate to accumulator.
// - Add flags carry above 255; subtract flags borrow below zero.
// - Increment and decrement by one, to memory or to accumulator.
// - AND, OR, XOR and complement via accumulator; zero flag on zero result.
// - Rotates move one bit; through-carry forms put the leaving bit in carry.
// - Call saves the next address, return resumes there, jump saves nothing.
// - Conditional skips test a memory value or a bit and skip the next.
// - Bit set and clear change only the chosen bit of a location.
// - Table read fetches a program memory word into the data path.
// - Halt enters power-down; a watchdog clear instruction exists.
// - Add and subtract update zero, carry, auxiliary carry and overflow.
`timescale 1ns/1ps
`default_nettype none
`include "core_params.svh"
module mcu_core
  import core_pkg::*;
(
  input  wire logic              ref_clk,    // 25 MHz system clock
  input  wire logic              resetn,     // Synchronous reset, active low
  output logic [`PC_W-1:0]       prog_addr,  // Program memory address
  input  wire logic [`IW-1:0]    prog_word,  // Program memory word
  output dm_req_t                dm_req,     // Data memory address, data, write
  input  wire logic [7:0]        dm_rdata,   // Data memory read data
  input  wire logic              wake_n,     // Wake-up pin, active low, async
  output logic [7:0]             acc,        // Accumulator
  output flags_t                 flags,      // Status flags
  output logic [5:0]             table_hi,   // Upper bits of last table word
  output logic                   power_down, // High while halted
  output logic                   wdt_clear   // One-clock watchdog clear pulse
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [1:0]        ph_q;
  seq_state_t        st_q;
  logic [`PC_W-1:0]  pc_q, stack_q, prog_addr_q;
  logic [`IW-1:0]    ir_q;
  logic [`DA_W-1:0]  dm_addr_q;
  logic [7:0]        acc_q, dm_wdata_q;
  logic [5:0]        table_hi_q;
  flags_t            flags_q, nf;
  logic              dm_we_q, wdt_q, tbl_q, wk1_q, wk2_q;

  // Decode fields and shared arithmetic
  logic [3:0]        cls;
  logic [2:0]        fn, afn, bsel;
  logic [1:0]        ifn;
  logic [7:0]        imm, opnd, b, mask, res;
  logic [8:0]        add9, sub9;
  logic [4:0]        addh, subh;
  logic              cin, exec_end, extra_end, pcl_wr, need_extra, wake;
  logic              wr_a, wr_m, skip, jump_op, call, ret, halt, wdt, tbl, bitop;
  logic [`PC_W-1:0]  pc_inc, pc_skip, pc_nx;

  assign cls  = ir_q[`CLS_HI:`CLS_LO];
  assign fn   = ir_q[`FN_HI:`FN_LO];
  assign ifn  = ir_q[`IFN_HI:`IFN_LO];
  assign imm  = ir_q[`IMM_HI:`IMM_LO];
  assign bsel = fn;
  assign mask = `BYTE_ONE << bsel;
  // The low program counter byte is visible as a data location
  assign opnd = (dm_addr_q == `PCL_ADDR) ? pc_q[7:0] : dm_rdata;
  assign b    = (cls == `CLS_IMM) ? imm : opnd;
  // Immediate functions map onto the shared ALU codes
  assign afn  = (cls != `CLS_IMM) ? fn :
                (ifn == `IF_ADD) ? `AF_ADD :
                (ifn == `IF_SUB) ? `AF_SUB : `AF_AND;
  assign cin  = ((afn == `AF_ADC) || (afn == `AF_SBC)) && flags_q.c;
  // Carry out of bit 7 and borrow below zero come from a ninth bit
  assign add9 = {1'b0, acc_q} + {1'b0, b} + {8'h00, cin};
  assign sub9 = {1'b0, acc_q} - {1'b0, b} - {8'h00, cin};
  assign addh = {1'b0, acc_q[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign subh = {1'b0, acc_q[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};

  assign exec_end  = (st_q == ST_EXEC) && (ph_q == `PH_LAST);
  assign extra_end = (st_q == ST_EXTRA) && (ph_q == `PH_LAST);
  assign wake      = ~wk2_q;

  // ----------------------------------------------------------------------
  // Execute: result, flags and control decisions of the held instruction
  // ----------------------------------------------------------------------
  always_comb
  begin
    res = opnd;
    nf = flags_q;
    wr_a = 1'b0;
    wr_m = 1'b0;
    skip = 1'b0;
    jump_op = 1'b0;
    call = 1'b0;
    ret = 1'b0;
    halt = 1'b0;
    wdt = 1'b0;
    tbl = 1'b0;
    bitop = 1'b0;
    case (cls)
      `CLS_ALU_A, `CLS_ALU_M, `CLS_IMM:
      begin
        wr_a = (cls != `CLS_ALU_M);
        wr_m = (cls == `CLS_ALU_M);
        case (afn)
          `AF_ADD, `AF_ADC:
          begin
            res = add9[7:0];
            nf = '{z: (add9[7:0] == 8'h00), c: add9[8], ac: addh[4],
                   ov: (acc_q[7] == b[7]) && (add9[7] != acc_q[7])};
          end
          `AF_SUB, `AF_SBC:
          begin
            res = sub9[7:0];
            nf = '{z: (sub9[7:0] == 8'h00), c: sub9[8], ac: subh[4],
                   ov: (acc_q[7] != b[7]) && (sub9[7] != acc_q[7])};
          end
          `AF_AND: res = acc_q & b;
          `AF_OR:  res = acc_q | b;
          `AF_XOR: res = acc_q ^ b;
          default: res = ~b;
        endcase
        if (afn >= `AF_AND)
          nf.z = (res == 8'h00);
        if ((cls == `CLS_IMM) && (ifn == `IF_MOV))
        begin
          res = imm;
          nf = flags_q;
        end
      end
      `CLS_UNI_A, `CLS_UNI_M:
      begin
        wr_a = (cls == `CLS_UNI_A);
        wr_m = (cls == `CLS_UNI_M);
        case (fn)
          `UF_INC: res = opnd + 8'h01;
          `UF_DEC: res = opnd - 8'h01;
          `UF_RR:  res = {opnd[0], opnd[7:1]};
          `UF_RL:  res = {opnd[6:0], opnd[7]};
          `UF_RRC:
          begin
            res = {flags_q.c, opnd[7:1]};
            nf.c = opnd[0];
          end
          `UF_RLC:
          begin
            res = {opnd[6:0], flags_q.c};
            nf.c = opnd[7];
          end
          `UF_MOV: res = (cls == `CLS_UNI_A) ? opnd : acc_q;
          default:
          begin
            // Accumulator form reads a table, memory form clears the location
            tbl = (cls == `CLS_UNI_A);
            wr_a = 1'b0;
            res = 8'h00;
          end
        endcase
        if ((fn == `UF_INC) || (fn == `UF_DEC))
          nf.z = (res == 8'h00);
      end
      `CLS_SKIP:
      begin
        case (fn)
          `SF_SZ:  skip = (opnd == 8'h00);
          `SF_SNZ: skip = (opnd != 8'h00);
          `SF_SIZ:
          begin
            res = opnd + 8'h01;
            wr_m = 1'b1;
            skip = (res == 8'h00);
          end
          `SF_SDZ:
          begin
            res = opnd - 8'h01;
            wr_m = 1'b1;
            skip = (res == 8'h00);
          end
          default: skip = 1'b0;
        endcase
      end
      `CLS_BSET, `CLS_BCLR:
      begin
        // Read-modify-write inside the core keeps the other bits intact
        bitop = 1'b1;
        wr_m = 1'b1;
        res = (cls == `CLS_BSET) ? (opnd | mask) : (opnd & ~mask);
      end
      `CLS_BSKZ:  skip = ~opnd[bsel];
      `CLS_BSKNZ: skip = opnd[bsel];
      `CLS_JMP:   jump_op = 1'b1;
      `CLS_CALL:  call = 1'b1;
      `CLS_SYS:
      begin
        ret = (fn == `YF_RET) || (fn == `YF_ISR_EXIT);
        halt = (fn == `YF_HALT);
        wdt = (fn == `YF_WDT);
      end
      default: res = opnd;
    endcase
  end

  // Control transfer and next program counter
  assign pcl_wr     = wr_m && (dm_addr_q == `PCL_ADDR);
  assign need_extra = jump_op | call | ret | tbl | pcl_wr | skip;
  assign pc_inc     = pc_q + `PC_W'(1);
  assign pc_skip    = pc_q + `PC_W'(2);
  assign pc_nx      = (jump_op | call) ? ir_q[`PC_W-1:0] :
                      ret ? stack_q :
                      pcl_wr ? {pc_q[`PC_W-1:8], res} :
                      skip ? pc_skip : pc_inc;

  // ----------------------------------------------------------------------
  // Phase counter and fetch latch
  // ----------------------------------------------------------------------
  // Four clocks per cycle: fetch in phase 0, operand settles, execute at end
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ph_q <= `PH_FIRST;
    else
      ph_q <= (ph_q == `PH_LAST) ? `PH_FIRST : ph_q + 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ir_q <= '0;
      dm_addr_q <= '0;
    end
    else if (ph_q == `PH_FETCH)
    begin
      ir_q <= prog_word;
      dm_addr_q <= prog_word[`DA_W-1:0];
    end
  end

  // Wake pin passes two flops before the halt logic sees it
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      {wk1_q, wk2_q} <= 2'h3;
    else
      {wk1_q, wk2_q} <= {wake_n, wk1_q};
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st_q <= ST_EXEC;
    else if (exec_end)
      st_q <= halt ? ST_HALT : (need_extra ? ST_EXTRA : ST_EXEC);
    else if (extra_end || ((st_q == ST_HALT) && (ph_q == `PH_LAST) && wake))
      st_q <= ST_EXEC;
  end

  // Program counter, stack and the table fetch address
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pc_q <= `PC_RST;
      stack_q <= `PC_RST;
      prog_addr_q <= `PC_RST;
      tbl_q <= 1'b0;
    end
    else if (exec_end)
    begin
      pc_q <= pc_nx;
      if (call)
        stack_q <= pc_inc;
      // The extra cycle of a table read fetches the table word
      prog_addr_q <= tbl ? {pc_q[`PC_W-1:8], opnd} : pc_nx;
      tbl_q <= tbl;
    end
    else if (extra_end)
    begin
      prog_addr_q <= pc_q;
      tbl_q <= 1'b0;
    end
  end

  // Accumulator and flags
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      acc_q <= `ACC_RST;
      flags_q <= '0;
      table_hi_q <= '0;
    end
    else if (exec_end)
    begin
      if (wr_a)
        acc_q <= res;
      flags_q <= nf;
    end
    else if (extra_end && tbl_q)
    begin
      acc_q <= ir_q[`IMM_HI:`IMM_LO];
      table_hi_q <= ir_q[`TBH_HI:`TBH_LO];
    end
  end

  // Memory write strobes during phase 0, while the old address still stands
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      dm_we_q <= 1'b0;
      dm_wdata_q <= '0;
      wdt_q <= 1'b0;
    end
    else
    begin
      dm_we_q <= exec_end && wr_m && !pcl_wr;
      if (exec_end)
        dm_wdata_q <= res;
      wdt_q <= exec_end && wdt;
    end
  end

  assign prog_addr  = prog_addr_q;
  assign dm_req     = '{addr: dm_addr_q, wdata: dm_wdata_q, we: dm_we_q};
  assign acc        = acc_q;
  assign flags      = flags_q;
  assign table_hi   = table_hi_q;
  assign power_down = (st_q == ST_HALT);
  assign wdt_clear  = wdt_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence extra_cycle_s;
    (st_q == ST_EXTRA) [*4] ##1 (st_q == ST_EXEC);
  endsequence

  AST_PHASE_WRAP: assert property ((ph_q == `PH_LAST) |=> (ph_q == `PH_FIRST))
    else $error("phase did not wrap after four clocks");
  AST_EXTRA_LEN: assert property ((exec_end && need_extra && !halt) |=> extra_cycle_s)
    else $error("extra cycle not exactly one instruction cycle");
  AST_JUMP_EXTRA: assert property ((exec_end && jump_op) |=> (pc_q == $past(ir_q[`PC_W-1:0])) && (st_q == ST_EXTRA))
    else $error("jump missed target or extra cycle");
  AST_PCL_JUMP: assert property ((exec_end && pcl_wr) |=> (pc_q[7:0] == $past(res)) && !dm_we_q)
    else $error("low byte write did not jump");
  AST_SKIP_PC: assert property ((exec_end && skip) |=> (pc_q == $past(pc_q) + `PC_W'(2)))
    else $error("taken skip did not pass one instruction");
  AST_CALL_RET: assert property ((exec_end && call) |=> (stack_q == $past(pc_q) + `PC_W'(1)))
    else $error("call saved wrong address");
  AST_RET_PC: assert property ((exec_end && ret) |=> (pc_q == $past(stack_q)))
    else $error("return did not resume at saved address");
  AST_BIT_ONLY: assert property ((exec_end && bitop && !pcl_wr) |=> dm_we_q && ($countones(dm_wdata_q ^ $past(opnd)) <= 1))
    else $error("bit operation touched other bits");
  AST_HALT: assert property ((exec_end && halt) |=> power_down [*4])
    else $error("halt did not enter power-down");
  AST_PC_STEP: assert property ((exec_end && !need_extra) |=> (pc_q == $past(pc_q) + `PC_W'(1)) && (st_q != ST_EXTRA))
    else $error("program counter did not advance by one");
  AST_ADD_CARRY: assert property ((exec_end && (cls == `CLS_ALU_A) && (afn == `AF_ADD)) |=> (flags.c == (({1'b0, $past(acc_q)} + {1'b0, $past(opnd)}) > 9'h0ff)))
    else $error("add carry wrong");
endmodule
`default_nettype wire

// >>> testbench/mcu_core_tb.sv
/*
  Self-checking bench for the instruction sequencing core. The program and data
  memories are arrays here. Each scenario loads a short program and checks the
  timing, results or flags at the ports.
  Assumes core_params.svh and core_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_params.svh"
module mcu_core_tb
  import core_pkg::*;
;
  // ----------------------------------------------------------------------
  // Clock, memories and design
  // ----------------------------------------------------------------------
  logic             ref_clk;
  logic             resetn;
  logic             wake_n;
  logic [`PC_W-1:0] prog_addr;
  logic [`IW-1:0]   rom [0:1023];
  logic [7:0]       ram [0:127];
  dm_req_t          dm_req;
  logic [7:0]       acc;
  flags_t           flags;
  logic [5:0]       table_hi;
  logic             power_down;
  logic             wdt_clear;
  int               n_fail;
  int               n_tests;
  int               n_wdt;
  localparam logic [13:0] NOP = 14'h3400; // Unused class 'hd, acts as no-op

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // Memories answer combinationally, as the core expects
  wire logic [`IW-1:0] prog_word = rom[prog_addr];
  wire logic [7:0]     dm_rdata  = ram[dm_req.addr];

  // Writes land on the old address; watchdog pulses are counted per clock
  always @(posedge ref_clk)
  begin
    if (dm_req.we === 1'b1)
      ram[dm_req.addr] <= dm_req.wdata;
    if (wdt_clear === 1'b1)
      n_wdt <= n_wdt + 1;
  end

  mcu_core mcu_core_i (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .prog_addr  (prog_addr),
    .prog_word  (prog_word),
    .dm_req     (dm_req),
    .dm_rdata   (dm_rdata),
    .wake_n     (wake_n),
    .acc        (acc),
    .flags      (flags),
    .table_hi   (table_hi),
    .power_down (power_down),
    .wdt_clear  (wdt_clear)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [13:0] op(logic [3:0] c, logic [2:0] f, logic [6:0] m);
    return {c, f, m};
  endfunction
  function automatic logic [13:0] imm(logic [1:0] f, logic [7:0] x);
    return {`CLS_IMM, f, x};
  endfunction
  function automatic logic [13:0] jump_op(logic [3:0] c, logic [9:0] a);
    return {c, a};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hold reset and blank the program so stray fetches do nothing
  task automatic hold;
    @(negedge ref_clk);
    resetn = 1'b0;
    wake_n = 1'b1;
    n_wdt  = 0;
    foreach (rom[i])
      rom[i] = NOP;
  endtask

  // Outputs are checked while reset is held, then it is released
  task automatic run;
    repeat (4) @(negedge ref_clk);
    chk("reset prog_addr", 16'h0000, 16'(prog_addr));
    chk("reset acc", 16'h0000, 16'(acc));
    chk("reset flags", 16'h0000, 16'(flags));
    chk("reset we", 16'h0000, 16'(dm_req.we));
    chk("reset power_down", 16'h0000, 16'(power_down));
    resetn = 1'b1;
  endtask

  // Bounded wait for an address; n > 0 also checks the clocks it took
  task automatic wa(input logic [9:0] a, input int n);
    int k;
    k = 0;
    while (prog_addr !== a && k < 40)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (prog_addr !== a)
    begin
      $display("mismatch prog_addr expected %h seen %h", a, prog_addr);
      n_fail++;
      close_out;
    end
    if (n > 0)
      chk("clocks to address", 16'(n), 16'(k));
  endtask

  task automatic ck(input logic [7:0] a, input logic [3:0] f, input logic [3:0] msk);
    chk("acc", 16'(a), 16'(acc));
    chk("flags", 16'(f & msk), 16'(4'(flags) & msk));
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Control transfers: an interval that follows a jump, call, return or low byte write includes that extra cycle
  task automatic t_flow;
    hold;
    rom[0]      = imm(`IF_MOV, 8'h40);
    rom[1]      = jump_op(`CLS_JMP, 10'h010);
    rom[10'h10] = jump_op(`CLS_CALL, 10'h020);
    rom[10'h20] = op(`CLS_SYS, `YF_RET, 7'h00);
    rom[10'h11] = op(`CLS_UNI_M, `UF_MOV, `PCL_ADDR);
    rom[10'h40] = jump_op(`CLS_CALL, 10'h050);
    rom[10'h50] = op(`CLS_SYS, `YF_ISR_EXIT, 7'h00);
    run;
    wa(10'h001, 4);
    wa(10'h010, 4);
    wa(10'h020, 8);
    wa(10'h011, 8);
    wa(10'h040, 8);
    wa(10'h050, 8);
    wa(10'h041, 8);
    wa(10'h042, 8);
    wa(10'h043, 4);
    $display("flow test done");
  endtask

  // Add and subtract flags, increment, decrement and moves
  task automatic t_arith;
    hold;
    ram[7'h20] = 8'h20;
    ram[7'h21] = 8'hff;
    ram[7'h22] = 8'h01;
    ram[7'h23] = 8'haa;
    rom[0]  = imm(`IF_MOV, 8'hf0);
    rom[1]  = op(`CLS_ALU_A, `AF_ADD, 7'h20);
    rom[2]  = imm(`IF_MOV, 8'h70);
    rom[3]  = imm(`IF_ADD, 8'h10);
    rom[4]  = imm(`IF_MOV, 8'h01);
    rom[5]  = op(`CLS_ALU_A, `AF_SUB, 7'h20);
    rom[6]  = op(`CLS_ALU_A, `AF_ADC, 7'h20);
    rom[7]  = op(`CLS_UNI_M, `UF_INC, 7'h21);
    rom[8]  = op(`CLS_UNI_A, `UF_DEC, 7'h22);
    rom[9]  = op(`CLS_UNI_M, `UF_MOV, 7'h23);
    rom[10] = op(`CLS_UNI_A, `UF_MOV, 7'h20);
    run;
    wa(10'd2, 0);
    ck(8'h10, 4'b0100, 4'hf);
    wa(10'd4, 0);
    ck(8'h80, 4'b0001, 4'hf);
    wa(10'd6, 0);
    ck(8'he1, 4'b0100, 4'hc);
    wa(10'd7, 0);
    ck(8'h02, 4'b0100, 4'hf);
    wa(10'd8, 0);
    ck(8'h02, 4'b1000, 4'h8);
    wa(10'd9, 0);
    ck(8'h00, 4'b1000, 4'h8);
    wa(10'd11, 0);
    chk("acc from memory", 16'h0020, 16'(acc));
    wa(10'd12, 0);
    chk("inc to memory", 16'h0000, 16'(ram[7'h21]));
    chk("dec source kept", 16'h0001, 16'(ram[7'h22]));
    chk("acc to memory", 16'h0000, 16'(ram[7'h23]));
    $display("arith test done");
  endtask

  // Logic ops, bit set and clear, rotates
  task automatic t_logic;
    hold;
    ram[7'h30] = 8'h0f;
    ram[7'h31] = 8'h5a;
    ram[7'h32] = 8'h81;
    rom[0]  = imm(`IF_MOV, 8'hf0);
    rom[1]  = op(`CLS_ALU_A, `AF_AND, 7'h30);
    rom[2]  = op(`CLS_ALU_A, `AF_OR, 7'h30);
    rom[3]  = op(`CLS_ALU_A, `AF_XOR, 7'h30);
    rom[4]  = op(`CLS_ALU_A, `AF_CPL, 7'h30);
    rom[5]  = op(`CLS_BSET, 3'd0, 7'h31);
    rom[6]  = op(`CLS_BCLR, 3'd6, 7'h31);
    rom[7]  = op(`CLS_UNI_A, `UF_RLC, 7'h32);
    rom[8]  = op(`CLS_UNI_A, `UF_RRC, 7'h32);
    rom[9]  = op(`CLS_UNI_A, `UF_RR, 7'h32);
    rom[10] = op(`CLS_UNI_A, `UF_RL, 7'h32);
    run;
    wa(10'd2, 0);
    ck(8'h00, 4'b1000, 4'h8);
    wa(10'd3, 0);
    ck(8'h0f, 4'b0000, 4'h8);
    wa(10'd4, 0);
    ck(8'h00, 4'b1000, 4'h8);
    wa(10'd5, 0);
    ck(8'hf0, 4'b0000, 4'h8);
    wa(10'd8, 0);
    ck(8'h02, 4'b0100, 4'h4);
    wa(10'd9, 0);
    ck(8'hc0, 4'b0100, 4'h4);
    wa(10'd10, 0);
    ck(8'hc0, 4'b0100, 4'h4);
    wa(10'd11, 0);
    chk("rotate left", 16'h0003, 16'(acc));
    chk("bit set and clear", 16'h001b, 16'(ram[7'h31]));
    chk("rotate source kept", 16'h0081, 16'(ram[7'h32]));
    $display("logic test done");
  endtask

  // Skips taken and not taken, then a table read of word 6
  task automatic t_skip;
    hold;
    ram[7'h40] = 8'h00;
    ram[7'h41] = 8'h01;
    ram[7'h42] = 8'h06;
    rom[0] = op(`CLS_SKIP, `SF_SZ, 7'h40);
    rom[1] = imm(`IF_MOV, 8'hee);
    rom[2] = op(`CLS_SKIP, `SF_SNZ, 7'h40);
    rom[3] = imm(`IF_MOV, 8'h11);
    rom[4] = op(`CLS_BSKNZ, 3'd0, 7'h41);
    rom[5] = imm(`IF_MOV, 8'hee);
    rom[6] = op(`CLS_BSKZ, 3'd0, 7'h41);
    rom[7] = imm(`IF_ADD, 8'h01);
    rom[8] = op(`CLS_UNI_A, `UF_X, 7'h42);
    run;
    wa(10'd3, 12);
    wa(10'd4, 4);
    chk("acc after skips", 16'h0011, 16'(acc));
    wa(10'd7, 12);
    wa(10'd8, 4);
    chk("acc after bit skips", 16'h0012, 16'(acc));
    // The table read shows the table address during its extra cycle, so 9 appears late
    wa(10'd9, 8);
    chk("table low", 16'h0041, 16'(acc));
    chk("table high", 16'h0020, 16'(table_hi));
    wa(10'd10, 4);
    $display("skip test done");
  endtask

  // Watchdog clear pulse, halt and wake-up
  task automatic t_halt;
    hold;
    rom[0] = op(`CLS_SYS, `YF_WDT, 7'h00);
    rom[1] = op(`CLS_SYS, `YF_HALT, 7'h00);
    rom[2] = imm(`IF_MOV, 8'h55);
    run;
    wa(10'd2, 8);
    repeat (20) @(negedge ref_clk);
    chk("watchdog pulses", 16'h0001, 16'(n_wdt));
    chk("halted", 16'h0001, 16'(power_down));
    chk("halted pc", 16'h0002, 16'(prog_addr));
    chk("halted acc", 16'h0000, 16'(acc));
    wake_n = 1'b0;
    wa(10'd3, 0);
    wake_n = 1'b1;
    chk("awake", 16'h0000, 16'(power_down));
    chk("acc after wake", 16'h0055, 16'(acc));
    $display("halt test done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    resetn  = 1'b0;
    wake_n  = 1'b1;
    n_fail  = 0;
    n_tests = 0;
    n_wdt   = 0;
    foreach (rom[i])
      rom[i] = NOP;
    foreach (ram[i])
      ram[i] = 8'h00;
    repeat (2) @(negedge ref_clk);
    t_flow;
    t_arith;
    t_logic;
    t_skip;
    t_halt;
    close_out;
  end
endmodule
`default_nettype wire
